/* jslt_link_timing.sv */
// Subclass 1 link timing: SYSREF capture, LMFC, multiframe start and SYNC~ handling
//
// Operation
// - LMFC boundary 40 clocks after SYSREF capture
// - Bypass: multiframe starts 52.7 clocks after LMFC
// - Single rate: 60.7 or 51.5 with five-four
// - Double rate: 52.7 or 43.9 with five-four
// - SYNC~ under four frames requests no resync
// - Alignment sequence lasts exactly four multiframes
// - Delays may grow by zero to three
// - Missed SYNC~ window keeps link running
`timescale 1ns/1ps
module jslt_link_timing
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sysref_i,
  input wire logic sync_n_i,
  input wire logic [5:0] decim_i,
  input wire logic double_rate_sel_i,
  input wire logic five_four_ratio_select_i,
  output logic sysref_edge_o,
  output logic lmfc_o,
  output logic frame_o,
  output logic mf_start_o,
  output logic cgs_o,
  output logic ilas_o,
  output logic user_data_o,
  output logic resync_o,
  output logic sync_window_err_o
);
  import jslt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic sysref_r;            // SYSREF sample this clock
  logic sysref_prev_r;       // SYSREF sample one clock earlier
  logic sysref_edge;         // Rising edge seen
  logic [7:0] lmfc_cnt_r;    // Countdown to the next LMFC boundary
  logic [7:0] lmfc_cnt_nxt;
  logic lmfc_hit;            // Boundary in this cycle
  logic lmfc_r;              // Registered boundary pulse
  logic [1:0] frame_cnt_r;   // Position inside a frame
  logic frame_r;             // Registered frame boundary pulse
  logic [5:0] tx_dly;        // Selected LMFC to multiframe delay
  logic mf_start;            // Multiframe start from the delay line
  logic sync_r;              // SYNC~ sample
  logic sync_prev_r;         // Previous SYNC~ sample
  logic sync_rise;           // SYNC~ released
  logic sync_chg;            // SYNC~ changed level
  logic [7:0] low_cnt_r;     // Clocks SYNC~ has been low, saturating
  logic low_long;            // Assertion long enough for a resync
  logic [7:0] since_chg_r;   // Clocks since the last SYNC~ change, saturating
  logic chg_pending_r;       // A change awaits its LMFC check
  logic win_bad;             // Change fell inside the forbidden window
  logic [2:0] ila_cnt_r;     // Multiframes of alignment sent
  logic resync_r;
  logic win_err_r;
  jslt_state_t state_r;
  jslt_state_t state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // SYSREF edge and LMFC phase
  assign sysref_edge = sysref_r & ~sysref_prev_r;
  assign lmfc_hit = (lmfc_cnt_r == 8'h00);
  // A captured edge reloads the countdown so the boundary lands 40 clocks later
  assign lmfc_cnt_nxt = sysref_edge ? 8'(SYSREF_TO_LMFC_CYC - 2) :
                        lmfc_hit ? 8'(LMFC_CYC - 1) :
                        lmfc_cnt_r - 8'h01;

  // Sample SYSREF and run the LMFC countdown
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sysref_r <= 1'b0;
      sysref_prev_r <= 1'b0;
      lmfc_cnt_r <= 8'(LMFC_CYC - 1);
      lmfc_r <= 1'b0;
    end
    else
    begin
      sysref_r <= sysref_i;
      sysref_prev_r <= sysref_r;
      lmfc_cnt_r <= lmfc_cnt_nxt;
      lmfc_r <= lmfc_hit & ~sysref_edge;
    end
  end

  // Frame boundaries follow the LMFC phase
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      frame_cnt_r <= 2'h0;
      frame_r <= 1'b0;
    end
    else
    begin
      frame_cnt_r <= (lmfc_hit & ~sysref_edge) ? 2'h1 : frame_cnt_r + 2'h1;
      frame_r <= (lmfc_hit & ~sysref_edge) | (frame_cnt_r == 2'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multiframe start delay selection
  // Bypass only runs double rate without five-four, so it shares that figure
  assign tx_dly = (decim_i == DECIM_BYPASS) ? TX_DDR_CYC :
                  (!double_rate_sel_i && !five_four_ratio_select_i) ? TX_SDR_CYC :
                  (!double_rate_sel_i && five_four_ratio_select_i) ? TX_SDR_P54_CYC :
                  five_four_ratio_select_i ? TX_DDR_P54_CYC :
                  TX_DDR_CYC;

  // Rounded-up fractions stay inside the allowed extra delay
  jslt_pulse_delay u_tx_dly
  (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .pulse_i(lmfc_r),
    .delay_i(tx_dly),
    .pulse_o(mf_start)
  );

  ////////////////////////////////////////////////////////////////////////////
  // SYNC~ sampling, length and window checks
  assign sync_rise = sync_r & ~sync_prev_r;
  assign sync_chg = sync_r ^ sync_prev_r;
  assign low_long = (low_cnt_r >= 8'(SYNC_MIN_CYC));
  assign win_bad = (since_chg_r > 8'(SYNC_HOLD_CYC)) &&
                   (since_chg_r < 8'(SYNC_SETUP_CYC));

  // Track SYNC~ low time and time since its last change
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sync_r <= 1'b1;
      sync_prev_r <= 1'b1;
      low_cnt_r <= 8'h00;
      since_chg_r <= 8'hff;
      chg_pending_r <= 1'b0;
    end
    else
    begin
      sync_r <= sync_n_i;
      sync_prev_r <= sync_r;
      // Counts low clocks of the current assertion only
      if (sync_r)
        low_cnt_r <= 8'h00;
      else if (low_cnt_r != 8'hff)
        low_cnt_r <= low_cnt_r + 8'h01;
      if (sync_chg)
        since_chg_r <= 8'h01;
      else if (since_chg_r != 8'hff)
        since_chg_r <= since_chg_r + 8'h01;
      // Change seen wins over the check that consumes it
      if (sync_chg)
        chg_pending_r <= 1'b1;
      else if (lmfc_r)
        chg_pending_r <= 1'b0;
    end
  end

  // Window result only flags lost alignment, sequencing is unaffected
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      win_err_r <= 1'b0;
    else if (lmfc_r && chg_pending_r)
      win_err_r <= win_bad;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link sequencing
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      // Hold code groups until a long enough SYNC~ is released
      ST_CGS:
      begin
        if (sync_rise && low_long)
          state_nxt = ST_WAIT;
      end
      // Alignment begins on the next multiframe start
      ST_WAIT:
      begin
        if (!sync_r && low_long)
          state_nxt = ST_CGS;
        else if (mf_start)
          state_nxt = ST_ILA;
      end
      // Four multiframes of alignment
      ST_ILA:
      begin
        if (!sync_r && low_long)
          state_nxt = ST_CGS;
        else if (mf_start && ila_cnt_r == 3'(ILA_MF - 1))
          state_nxt = ST_DATA;
      end
      // User data; short SYNC~ pulses are ignored
      ST_DATA:
      begin
        if (!sync_r && low_long)
          state_nxt = ST_CGS;
      end
    endcase
  end

  // State, alignment counter and resync pulse
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_CGS;
      ila_cnt_r <= 3'h0;
      resync_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      resync_r <= sync_rise & low_long;
      if (state_r != ST_ILA)
        ila_cnt_r <= 3'h0;
      else if (mf_start)
        ila_cnt_r <= ila_cnt_r + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign sysref_edge_o = sysref_edge;
  assign lmfc_o = lmfc_r;
  assign frame_o = frame_r;
  assign mf_start_o = mf_start;
  assign cgs_o = (state_r == ST_CGS) || (state_r == ST_WAIT);
  assign ilas_o = (state_r == ST_ILA);
  assign user_data_o = (state_r == ST_DATA);
  assign resync_o = resync_r;
  assign sync_window_err_o = win_err_r;
endmodule

/* jslt_link_timing_chk.sv */
// Port assertions for the link timing block
`timescale 1ns/1ps
module jslt_link_timing_chk
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sysref_i,
  input wire logic sync_n_i,
  input wire logic sysref_edge_o,
  input wire logic lmfc_o,
  input wire logic frame_o,
  input wire logic mf_start_o,
  input wire logic cgs_o,
  input wire logic ilas_o,
  input wire logic user_data_o,
  input wire logic resync_o
);
  logic [7:0] lmfc_cnt_r;  // Cycles since last boundary
  logic [7:0] ila_cnt_r;  // Cycles of alignment sequence so far
  logic edge_seen_r;  // Realign pending until next boundary
  logic started_r;  // First boundary seen
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Helper counters
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      lmfc_cnt_r <= 8'h00;
      ila_cnt_r <= 8'h00;
      edge_seen_r <= 1'b0;
      started_r <= 1'b0;
    end
    else
    begin
      lmfc_cnt_r <= lmfc_o ? 8'h00 : lmfc_cnt_r + 8'h01;
      ila_cnt_r <= ilas_o ? ila_cnt_r + 8'h01 : 8'h00;
      edge_seen_r <= sysref_edge_o | (edge_seen_r & ~lmfc_o);
      started_r <= started_r | lmfc_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_edge_detect: assert property (sysref_edge_o == ($past(sysref_i) && !$past(sysref_i, 2)))
    else $error("sysref edge not from two samples");
  a_lmfc_after_edge: assert property (sysref_edge_o |-> ##[40:43] lmfc_o)
    else $error("boundary not 40 clocks after sysref");
  a_lmfc_period: assert property (started_r && !edge_seen_r && !sysref_edge_o |-> lmfc_o == (lmfc_cnt_r == 8'h1f))
    else $error("boundary period wrong");
  a_frame_on_lmfc: assert property (lmfc_o |-> frame_o)
    else $error("frame not aligned to boundary");
  a_frame_period: assert property (frame_o && !edge_seen_r && !sysref_edge_o |=> !frame_o [*3] ##1 frame_o)
    else $error("frame period not four clocks");
  a_resync_cause: assert property (resync_o |-> $past(sync_n_i, 2) && !$past(sync_n_i, 3) && !$past(sync_n_i, 18))
    else $error("resync without long assertion");
  a_resync_pulse: assert property (resync_o |-> cgs_o ##1 !resync_o)
    else $error("resync pulse too long");
  a_state_onehot: assert property ($onehot({cgs_o, ilas_o, user_data_o}))
    else $error("link state not one hot");
  a_ila_on_mf: assert property ($rose(ilas_o) |-> $past(mf_start_o))
    else $error("alignment not on multiframe start");
  a_ila_bound: assert property (ilas_o |-> ila_cnt_r < 8'h80)
    else $error("alignment sequence too long");
  a_data_after_ila: assert property ($rose(user_data_o) |-> $past(ilas_o) && ila_cnt_r == 8'h80)
    else $error("user data not after four multiframes");
  c_realign: cover property (sysref_edge_o ##[40:43] lmfc_o);
  c_resync: cover property (resync_o);
  c_data: cover property ($rose(user_data_o));
endmodule

bind jslt_link_timing jslt_link_timing_chk u_chk (.clk_sys_i, .rst_i, .sysref_i, .sync_n_i, .sysref_edge_o,
  .lmfc_o, .frame_o, .mf_start_o, .cgs_o, .ilas_o, .user_data_o, .resync_o);

/* jslt_link_timing_test.sv */
// Self-checking testbench for the link timing block
`timescale 1ns/1ps
module jslt_link_timing_test;
  import jslt_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic sysref_i = 1'b0;
  logic [5:0] decim_i = DECIM_BYPASS;
  logic double_rate_sel_i = 1'b1;
  logic five_four_ratio_select_i = 1'b0;
  logic sync_n_i, sysref_edge_o, lmfc_o, frame_o, mf_start_o, cgs_o, ilas_o, user_data_o, resync_o;
  logic sync_window_err_o;
  int n_mismatch = 0;
  int n_tests = 0;
  always #50 clk_sys_i = ~clk_sys_i;  // 10 MHz
  jslt_link_timing dut (.clk_sys_i, .rst_i, .sysref_i, .sync_n_i, .decim_i, .double_rate_sel_i,
    .five_four_ratio_select_i, .sysref_edge_o, .lmfc_o, .frame_o, .mf_start_o, .cgs_o, .ilas_o,
    .user_data_o, .resync_o, .sync_window_err_o);
  jslt_rx_model rx (.clk_sys_i, .lmfc_i(lmfc_o), .sync_n_o(sync_n_i));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check_bit(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %b seen %b", name, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic check_rng(input string name, input int lo, input int hi, input int got);
    n_tests++;
    if (got < lo || got > hi)
    begin
      $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, got);
      n_mismatch++;
    end
  endtask
  // Select an output to wait on
  function automatic logic pick(input int s);
    case (s)
      0: return lmfc_o;
      1: return mf_start_o;
      2: return resync_o;
      3: return ilas_o;
      4: return user_data_o;
      default: return sysref_edge_o;
    endcase
  endfunction
  // Count falling edges until the output is high, bounded
  task automatic wait_for(input int s, input int lim, output int n);
    n = 0;
    do
    begin
      @(negedge clk_sys_i);
      n++;
    end
    while (n < lim && pick(s) !== 1'b1);
    if (pick(s) !== 1'b1)
    begin
      $display("wrong value wait %0d expected 1 seen 0", s);
      n_mismatch++;
      conclude();
    end
  endtask
  // One SYNC~ assertion from the receiver model; a missing boundary ends the run
  task automatic sync_low(input int unsigned off, input int unsigned len);
    logic found;
    rx.hold_low(off, len, found);
    check_bit("boundary before sync", 1'b1, found);
    if (found !== 1'b1)
      conclude();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_sysref();
    int n;
    sysref_i = 1'b1;  // Held high well over 8 clocks
    wait_for(5, 4, n);
    check_rng("edge delay", 1, 1, n);
    wait_for(0, 60, n);
    check_rng("sysref to lmfc", 40, 43, n);
    sysref_i = 1'b0;
    wait_for(0, 40, n);
    check_rng("lmfc period", LMFC_CYC, LMFC_CYC, n);
    $display("test sysref done");
  endtask
  task automatic t_mf();
    logic [5:0] dm [4] = '{DECIM_BYPASS, 6'h08, 6'h08, 6'h04};
    logic dr [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    logic p5 [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    int x10 [4] = '{TX_DDR_X10, TX_SDR_X10, TX_SDR_P54_X10, TX_DDR_P54_X10};
    int n;
    int d;
    int h;
    for (int i = 0; i < 4; i++)
    begin
      decim_i = dm[i];
      double_rate_sel_i = dr[i];
      five_four_ratio_select_i = p5[i];
      repeat (3) wait_for(0, 40, n);  // Let the delay line refill
      wait_for(1, 40, n);
      d = (x10[i] + 9) / 10 - LMFC_CYC;  // Start lags into the next multiframe
      h = (x10[i] + 30) / 10 - LMFC_CYC;  // Up to three clocks of extra delay
      check_rng("multiframe start", d, h, n);
    end
    $display("test multiframe done");
  endtask
  task automatic t_short();
    logic seen;
    logic cgs_before;
    seen = 1'b0;
    cgs_before = cgs_o;
    sync_low(24, 8);
    repeat (40)
    begin
      @(negedge clk_sys_i);
      seen = seen | resync_o;
    end
    check_bit("short resync", 1'b0, seen);
    check_bit("state kept", cgs_before, cgs_o);
    $display("test short sync done");
  endtask
  task automatic t_link(input int unsigned off, input int unsigned len);
    int n;
    sync_low(off, len);
    wait_for(2, 8, n);
    check_rng("resync delay", 1, 3, n);
    wait_for(3, 80, n);
    wait_for(4, 200, n);
    check_rng("ila length", 4 * LMFC_CYC, 4 * LMFC_CYC, n);
    check_bit("cgs off", 1'b0, cgs_o);
    check_bit("window error", (off != 24), sync_window_err_o);
    $display("test link done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    t_sysref();
    t_mf();
    t_short();
    t_link(24, 32);
    t_short();
    t_link(8, 30);
    conclude();
  end
endmodule

/* jslt_pkg.sv */
// Constants and types for the JESD204B subclass 1 link timing block
package jslt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame and multiframe shape, in sampling-clock periods
  localparam int unsigned FRAME_CLKS = 4;           // Sampling clocks per frame
  localparam int unsigned FRAMES_PER_MF = 8;        // Frames per multiframe (K)
  localparam int unsigned LMFC_CYC = FRAME_CLKS * FRAMES_PER_MF;

  ////////////////////////////////////////////////////////////////////////////
  // SYSREF to LMFC boundary, in sampling periods
  localparam int unsigned SYSREF_TO_LMFC_CYC = 40;

  ////////////////////////////////////////////////////////////////////////////
  // LMFC to multiframe start, in tenths of a sampling period
  localparam int unsigned TX_DDR_X10 = 527;         // Double rate, five-four clear
  localparam int unsigned TX_DDR_P54_X10 = 439;     // Double rate, five-four set
  localparam int unsigned TX_SDR_X10 = 607;         // Single rate, five-four clear
  localparam int unsigned TX_SDR_P54_X10 = 515;     // Single rate, five-four set
  // Fractions round up to whole cycles
  localparam logic [5:0] TX_DDR_CYC = 6'((TX_DDR_X10 + 9) / 10);
  localparam logic [5:0] TX_DDR_P54_CYC = 6'((TX_DDR_P54_X10 + 9) / 10);
  localparam logic [5:0] TX_SDR_CYC = 6'((TX_SDR_X10 + 9) / 10);
  localparam logic [5:0] TX_SDR_P54_CYC = 6'((TX_SDR_P54_X10 + 9) / 10);

  ////////////////////////////////////////////////////////////////////////////
  // SYNC~ timing
  localparam int unsigned SYNC_MIN_FRAMES = 4;      // Least assertion for a resync
  localparam int unsigned SYNC_MIN_CYC = SYNC_MIN_FRAMES * FRAME_CLKS;
  localparam int unsigned SYNC_SETUP_CYC = 40;      // Change at least this early
  localparam int unsigned SYNC_HOLD_CYC = 8;        // Stable until this many before
  localparam int unsigned ILA_MF = 4;               // Alignment sequence length

  ////////////////////////////////////////////////////////////////////////////
  // Delay line depth and decimation code for bypass
  localparam int unsigned DLY_DEPTH = 64;
  localparam logic [5:0] DECIM_BYPASS = 6'h01;

  // Link sequencing states
  typedef enum logic [1:0] {ST_CGS, ST_WAIT, ST_ILA, ST_DATA} jslt_state_t;

endpackage

/* jslt_pulse_delay.sv */
// Tapped shift register that delays a pulse by a selectable cycle count
`timescale 1ns/1ps
module jslt_pulse_delay
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic pulse_i,
  input wire logic [5:0] delay_i,
  output logic pulse_o
);
  import jslt_pkg::*;

  logic [jslt_pkg::DLY_DEPTH-1:0] sr_r;    // Delay line
  logic [5:0] tap; // Tap index, two less than the delay because of the two flops
  logic tap_bit;

  assign tap = delay_i - 6'h02;
  assign tap_bit = sr_r[tap];

  ////////////////////////////////////////////////////////////////////////////
  // Shift the pulse in and register the selected tap
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sr_r <= '0;
      pulse_o <= 1'b0;
    end
    else
    begin
      sr_r <= {sr_r[DLY_DEPTH-2:0], pulse_i};
      pulse_o <= tap_bit;
    end
  end
endmodule

/* jslt_rx_model.sv */
// Behavioural receiver model that drives SYNC~ against the LMFC
`timescale 1ns/1ps
module jslt_rx_model
(
  input wire logic clk_sys_i,
  input wire logic lmfc_i,
  output logic sync_n_o
);
  initial sync_n_o = 1'b1;  // Released at start

  ////////////////////////////////////////////////////////////////////////////
  // Drive SYNC~ low for n clocks, starting off clocks after a boundary
  // Found stays low when no boundary came within the bound
  task automatic hold_low(input int unsigned off, input int unsigned n, output logic found);
    int unsigned k;
    k = 0;
    while (k < 64 && lmfc_i !== 1'b1)
    begin
      @(negedge clk_sys_i);
      k++;
    end
    found = (lmfc_i === 1'b1);
    repeat (off) @(negedge clk_sys_i);  // Offset 24 is sampled 7 clocks before the next boundary
    sync_n_o = 1'b0;
    repeat (n) @(negedge clk_sys_i);  // Low at least four frames to resync
    sync_n_o = 1'b1;
  endtask
endmodule
